// File: verilog/icu_top.sv
// Interrupt control unit: flags, enables, stack push/pop and AXI4-Lite registers
//
// Contract
// R1 - Four sources: external pin, comparator, wide timer, narrow timer.
// R2 - Each source has its own enable bit blocking its interrupt entry.
// R3 - Hardware sets flags on events; only software writes clear them.
// R4 - Flags set on rising, falling or both edges per edge select.
// R5 - Global enable gates all; set by enable, cleared by disable instruction. Here it gates entry only; irq_out ignores it.
// R6 - Flags still set when the source enable is zero.
// R7 - Entry pushes PC at stack pointer, adds two, clears global enable.
// R8 - After entry the next fetch comes from the fixed vector address.
// R9 - Return pops PC, subtracts two, sets global enable, resumes.
// R10 - Flag register is readable so software can find the source.
// R11 - Software keeps stack pointer bit zero at zero.
// R12 - Accumulator and flags push/pop use the same stack memory.
// R13 - Software reserves two stack bytes per nesting level and push.
// R14 - Service routines should clear only the flag they handled.
// R15 - Software enables the pin's digital input when used for interrupts.
// R16 - A set and a clear in the same cycle leave the flag set.
// R17 - A pending request is taken only after the current instruction ends.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
module icu_top
  import icu_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Request sources
  input wire logic external_request_pin_in,
  input wire logic comparator_unit_in,
  input wire logic wide_timer_in,
  input wire logic narrow_timer_in,
  // Core side
  input wire icu_core_req_t core_req_in,
  input wire logic [15:0] mem_rdata_in,
  output icu_core_rsp_t core_rsp_out,
  output logic global_enable_out,
  output logic [7:0] stack_pointer_out,
  output logic irq_out,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // State record
  typedef struct packed {
    icu_state_t state;
    logic [ICU_NSRC-1:0] flag;
    logic [ICU_NSRC-1:0] enable;
    logic [2*ICU_NSRC-1:0] edge_sel;
    logic global_en;
    logic [7:0] sp;
    logic [ICU_NSRC-1:0] irq_stat;
    logic [ICU_NSRC-1:0] irq_mask;
    icu_core_rsp_t rsp;
    logic irq;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } icu_regs_t;

  icu_regs_t s_r;
  icu_regs_t s_nxt;

  logic [ICU_NSRC-1:0] src_level;
  logic [ICU_NSRC-1:0] src_event;

  // ==========================================================
  // Source gathering and edge detection
  assign src_level[ICU_SRC_PIN] = external_request_pin_in; // R1
  assign src_level[ICU_SRC_CMP] = comparator_unit_in; // R1
  assign src_level[ICU_SRC_WT] = wide_timer_in; // R1
  assign src_level[ICU_SRC_NT] = narrow_timer_in; // R1

  icu_edge_detect u_edge (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .level_in(src_level),
    .edge_sel_in(s_r.edge_sel),
    .event_out(src_event)
  );

  // Byte-lane merge, used for every writable register except the status register
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = data[8*i +: 8];
    end
    lane_merge = res;
  endfunction

  // Address decode shared by read and write
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ICU_OFS_FLAG) || (a == ICU_OFS_ENABLE) || (a == ICU_OFS_EDGE) ||
              (a == ICU_OFS_GLOBAL) || (a == ICU_OFS_SP) || (a == ICU_OFS_IRQ_STAT) ||
              (a == ICU_OFS_IRQ_MASK);
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    logic [31:0] wv;
    logic [ICU_NSRC-1:0] clr;
    logic [ICU_NSRC-1:0] stat_clr;
    logic take;
    logic do_write;
    wv = '0;
    clr = '0;
    stat_clr = '0;
    take = 1'b0;
    do_write = 1'b0;
    s_nxt = s_r;
    s_nxt.rsp.mem_we = 1'b0;
    s_nxt.rsp.mem_re = 1'b0;
    s_nxt.rsp.pc_load = 1'b0;

    // Write address and data taken in either order
    if (s_axi_awvalid && s_r.awready)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
      s_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && s_r.wready)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
      s_nxt.wready = 1'b0;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
    begin
      do_write = 1'b1;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = addr_ok(s_r.aw_addr) ? ICU_RESP_OKAY : ICU_RESP_SLVERR;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
    end
    if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end

    // Register writes; flag bits clear where a zero is written, status bits where a one is written
    if (do_write)
    begin
      unique case (s_r.aw_addr)
        ICU_OFS_FLAG:
        begin
          wv = lane_merge({28'h0, s_r.flag}, s_r.w_data, s_r.w_strb);
          clr = s_r.flag & ~wv[ICU_NSRC-1:0]; // R3
        end
        ICU_OFS_ENABLE:
        begin
          wv = lane_merge({28'h0, s_r.enable}, s_r.w_data, s_r.w_strb);
          s_nxt.enable = wv[ICU_NSRC-1:0];
        end
        ICU_OFS_EDGE:
        begin
          wv = lane_merge({24'h0, s_r.edge_sel}, s_r.w_data, s_r.w_strb);
          s_nxt.edge_sel = wv[2*ICU_NSRC-1:0];
        end
        ICU_OFS_GLOBAL:
        begin
          wv = lane_merge({31'h0, s_r.global_en}, s_r.w_data, s_r.w_strb);
          s_nxt.global_en = wv[0];
        end
        ICU_OFS_SP:
        begin
          wv = lane_merge({24'h0, s_r.sp}, s_r.w_data, s_r.w_strb);
          s_nxt.sp = wv[7:0];
        end
        ICU_OFS_IRQ_STAT:
        begin
          if (s_r.w_strb[0])
            stat_clr = s_r.w_data[ICU_NSRC-1:0];
        end
        ICU_OFS_IRQ_MASK:
        begin
          wv = lane_merge({28'h0, s_r.irq_mask}, s_r.w_data, s_r.w_strb);
          s_nxt.irq_mask = wv[ICU_NSRC-1:0];
        end
        default: wv = '0;
      endcase
    end

    // Flags set regardless of enables, and set beats clear
    s_nxt.flag = (s_r.flag & ~clr) | src_event; // R3 R6 R16
    s_nxt.irq_stat = (s_r.irq_stat & ~stat_clr) | src_event; // R16
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

    // Read channel, one outstanding read
    if (s_axi_arvalid && s_r.arready)
    begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = addr_ok(s_axi_araddr) ? ICU_RESP_OKAY : ICU_RESP_SLVERR;
      unique case (s_axi_araddr)
        ICU_OFS_FLAG: s_nxt.rdata = {28'h0, s_r.flag}; // R10
        ICU_OFS_ENABLE: s_nxt.rdata = {28'h0, s_r.enable};
        ICU_OFS_EDGE: s_nxt.rdata = {24'h0, s_r.edge_sel};
        ICU_OFS_GLOBAL: s_nxt.rdata = {31'h0, s_r.global_en};
        ICU_OFS_SP: s_nxt.rdata = {24'h0, s_r.sp};
        ICU_OFS_IRQ_STAT: s_nxt.rdata = {28'h0, s_r.irq_stat};
        ICU_OFS_IRQ_MASK: s_nxt.rdata = {28'h0, s_r.irq_mask};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // Global enable instructions; ignored while entry or return runs
    if (s_r.state == ICU_IDLE)
    begin
      if (core_req_in.enable_global)
        s_nxt.global_en = 1'b1; // R5
      if (core_req_in.disable_global)
        s_nxt.global_en = 1'b0; // R5
    end

    // Entry and return sequencer
    take = s_r.global_en && |(s_r.flag & s_r.enable); // R2 R5
    unique case (s_r.state)
      ICU_IDLE:
      begin
        if (core_req_in.instr_done && core_req_in.reti)
        begin
          // Pop reads the word just below the pointer
          s_nxt.rsp.mem_re = 1'b1; // R9
          s_nxt.rsp.mem_addr = s_r.sp - ICU_SP_STEP;
          s_nxt.rsp.entry_busy = 1'b1;
          s_nxt.state = ICU_POP;
        end
        else if (core_req_in.instr_done && take) // R17
        begin
          s_nxt.rsp.mem_we = 1'b1; // R7 R12
          s_nxt.rsp.mem_addr = s_r.sp;
          s_nxt.rsp.mem_wdata = core_req_in.pc;
          s_nxt.rsp.pc_load = 1'b1; // R8
          s_nxt.rsp.pc_value = ICU_VECTOR; // R8
          s_nxt.rsp.entry_busy = 1'b1;
          s_nxt.sp = s_r.sp + ICU_SP_STEP; // R7
          s_nxt.global_en = 1'b0; // R7
          s_nxt.state = ICU_PUSH;
        end
      end
      ICU_PUSH:
      begin
        s_nxt.rsp.entry_busy = 1'b0;
        s_nxt.state = ICU_IDLE;
      end
      ICU_POP:
        s_nxt.state = ICU_POP_WAIT;
      ICU_POP_WAIT:
      begin
        // Memory answers one cycle after the read strobe
        s_nxt.rsp.pc_load = 1'b1; // R9
        s_nxt.rsp.pc_value = mem_rdata_in; // R9
        s_nxt.rsp.entry_busy = 1'b0;
        s_nxt.sp = s_r.sp - ICU_SP_STEP; // R9
        s_nxt.global_en = 1'b1; // R9
        s_nxt.state = ICU_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register with clock enable
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      s_r <= '0;
      s_r.state <= ICU_IDLE;
      s_r.flag <= ICU_FLAG_RST;
      s_r.enable <= ICU_ENABLE_RST;
      s_r.edge_sel <= ICU_EDGE_RST;
      s_r.sp <= ICU_SP_RST;
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
    end
    else if (ce_in)
      s_r <= s_nxt;
  end

  // ==========================================================
  // Outputs straight from flip-flops
  assign core_rsp_out = s_r.rsp;
  assign global_enable_out = s_r.global_en;
  assign stack_pointer_out = s_r.sp;
  assign irq_out = s_r.irq;
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rvalid = s_r.rvalid;

endmodule // icu_top

// File: verilog/icu_pkg.sv
// Package of constants and carrier types for the interrupt control unit
package icu_pkg;

  // ==========================================================
  // Sources and widths
  localparam int ICU_NSRC = 4;
  localparam int ICU_SRC_PIN = 0;
  localparam int ICU_SRC_CMP = 1;
  localparam int ICU_SRC_WT = 2;
  localparam int ICU_SRC_NT = 3;

  // ==========================================================
  // Register map (byte offsets on AXI4-Lite)
  localparam logic [7:0] ICU_OFS_FLAG = 8'h00;
  localparam logic [7:0] ICU_OFS_ENABLE = 8'h04;
  localparam logic [7:0] ICU_OFS_EDGE = 8'h08;
  localparam logic [7:0] ICU_OFS_GLOBAL = 8'h0c;
  localparam logic [7:0] ICU_OFS_SP = 8'h10;
  localparam logic [7:0] ICU_OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] ICU_OFS_IRQ_MASK = 8'h18;

  // ==========================================================
  // Reset values and fixed addresses
  localparam logic [3:0] ICU_FLAG_RST = 4'h0;
  localparam logic [3:0] ICU_ENABLE_RST = 4'h0;
  localparam logic [7:0] ICU_EDGE_RST = 8'h00;
  localparam logic [7:0] ICU_SP_RST = 8'h00;
  localparam logic [15:0] ICU_VECTOR = 16'h0010;
  localparam logic [7:0] ICU_SP_STEP = 8'h02;
  localparam logic [1:0] ICU_RESP_OKAY = 2'h0;
  localparam logic [1:0] ICU_RESP_SLVERR = 2'h2;

  // Edge select codes, two bits per source
  localparam logic [1:0] ICU_EDGE_BOTH = 2'h0;
  localparam logic [1:0] ICU_EDGE_RISE = 2'h1;
  localparam logic [1:0] ICU_EDGE_FALL = 2'h2;

  // ==========================================================
  // Core-side carriers
  typedef struct packed {
    logic instr_done;
    logic enable_global;
    logic disable_global;
    logic reti;
    logic [15:0] pc;
  } icu_core_req_t;

  typedef struct packed {
    logic mem_we;
    logic mem_re;
    logic [7:0] mem_addr;
    logic [15:0] mem_wdata;
    logic pc_load;
    logic [15:0] pc_value;
    logic entry_busy;
  } icu_core_rsp_t;

  typedef enum logic [1:0] {
    ICU_IDLE,
    ICU_PUSH,
    ICU_POP,
    ICU_POP_WAIT
  } icu_state_t;

endpackage : icu_pkg

// File: verilog/icu_edge_detect.sv
// Per-source edge detector with selectable sensitivity
`timescale 1ns/1ns
module icu_edge_detect
  import icu_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [ICU_NSRC-1:0] level_in,
  input wire logic [2*ICU_NSRC-1:0] edge_sel_in,
  output logic [ICU_NSRC-1:0] event_out
);

  // ==========================================================
  // Decode of one source's sensitivity
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    unique case (sel)
      ICU_EDGE_RISE: edge_hit = rise;
      ICU_EDGE_FALL: edge_hit = fall;
      ICU_EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  logic [ICU_NSRC-1:0] prev_r;

  // Previous level held for comparison
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      prev_r <= '0;
    else if (ce_in)
      prev_r <= level_in;
  end

  // Event is combinational so a flag sets on the edge's own cycle
  genvar g;
  generate
    for (g = 0; g < ICU_NSRC; g++)
    begin : g_src
      assign event_out[g] = ce_in & edge_hit(edge_sel_in[2*g +: 2], prev_r[g], level_in[g]); // R4
    end
  endgenerate

endmodule // icu_edge_detect

// File: verif/icu_asserts.sv
// Port-level checker for the interrupt control unit
`timescale 1ns/1ns
module icu_asserts
  import icu_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire icu_core_req_t core_req_in,
  input wire logic [15:0] mem_rdata_in,
  input wire icu_core_rsp_t core_rsp_out,
  input wire logic global_enable_out,
  input wire logic [7:0] stack_pointer_out,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // ==========================================================
  // Core side
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  entry_push_a: assert property (core_rsp_out.mem_we |-> core_rsp_out.pc_load && core_rsp_out.pc_value == ICU_VECTOR
    && core_rsp_out.mem_addr == $past(stack_pointer_out) && stack_pointer_out == core_rsp_out.mem_addr + ICU_SP_STEP
    && !global_enable_out) else $error("entry push wrong");
  entry_cause_a: assert property (core_rsp_out.mem_we |-> $past(core_req_in.instr_done) && $past(global_enable_out)
    && core_rsp_out.mem_wdata == $past(core_req_in.pc)) else $error("entry without cause");
  entry_pulse_a: assert property (core_rsp_out.mem_we |=> !core_rsp_out.mem_we && !core_rsp_out.entry_busy)
    else $error("entry pulse too long");
  pop_restore_a: assert property (core_rsp_out.mem_re |-> core_rsp_out.mem_addr == stack_pointer_out - ICU_SP_STEP
    ##2 core_rsp_out.pc_load && global_enable_out && stack_pointer_out == $past(core_rsp_out.mem_addr, 2)
    && core_rsp_out.pc_value == $past(mem_rdata_in)) else $error("return restore wrong");

  // ==========================================================
  // Register bus, valid held until taken
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data unstable");
endmodule // icu_asserts

bind icu_top icu_asserts u_chk (.clk_in, .rstn_in, .core_req_in, .mem_rdata_in, .core_rsp_out, .global_enable_out,
  .stack_pointer_out, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// File: verif/icu_core_model.sv
// Behavioural processor core: instruction stream, program counter and stack memory
`timescale 1ns/1ns
module icu_core_model
  import icu_pkg::*;
#(
  parameter logic [15:0] PC_START = 16'h1234
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic slow_in,
  input wire logic [2:0] op_in,
  input wire icu_core_rsp_t core_rsp_in,
  output icu_core_req_t core_req_out,
  output logic [15:0] mem_rdata_out
);
  logic [2:0] pend;
  logic [1:0] cnt;
  logic done;
  logic go;
  logic [15:0] pc;
  logic [15:0] mem [0:127];

  // Slow mode ends an instruction every fourth cycle only
  assign done = !slow_in || cnt == 2'h3;
  assign go = done && !core_rsp_in.entry_busy;

  // ==========================================================
  // Core step: ops wait for an instruction boundary
  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      pend <= 3'h0;
      cnt <= 2'h0;
      pc <= PC_START;
      core_req_out <= '0;
      mem_rdata_out <= 16'hffff;
    end
    else
    begin
      cnt <= cnt + 2'h1;
      core_req_out <= {done, go && pend[0], go && pend[1], go && pend[2], pc};
      pend <= (go ? 3'h0 : pend) | op_in;
      // Shared data memory holds the saved word at an even address
      if (core_rsp_in.mem_we)
        mem[core_rsp_in.mem_addr[7:1]] <= core_rsp_in.mem_wdata;
      // Read data lasts one cycle, then the bus shows garbage
      mem_rdata_out <= core_rsp_in.mem_re ? mem[core_rsp_in.mem_addr[7:1]] : ~mem_rdata_out;
      if (core_rsp_in.pc_load)
        pc <= core_rsp_in.pc_value;
    end
  end
endmodule // icu_core_model

// File: verif/icu_top_tb.sv
// Self-checking bench for the interrupt control unit
`timescale 1ns/1ns
module icu_top_tb
  import icu_pkg::*;
;
  localparam logic [15:0] PC0 = 16'h1234;
  logic clk_in = 0;
  logic rstn_in = 0;
  logic slow = 0;
  logic ce = 1;
  logic [3:0] src = 0;
  logic [2:0] op = 0;
  logic [7:0] s_axi_awaddr = 0;
  logic [7:0] s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ge, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] sp;
  logic [15:0] mrd;
  icu_core_req_t creq;
  icu_core_rsp_t crsp;
  int n_fail = 0, checks_done = 0, cyc = 0, seed = 32'h7984a648;
  int fl, st, old, nw, ev, c, k;

  icu_top u_dut (.clk_in, .rstn_in, .ce_in(ce), .external_request_pin_in(src[0]), .comparator_unit_in(src[1]),
    .wide_timer_in(src[2]), .narrow_timer_in(src[3]), .core_req_in(creq), .mem_rdata_in(mrd), .core_rsp_out(crsp),
    .global_enable_out(ge), .stack_pointer_out(sp), .irq_out(irq), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  icu_core_model #(.PC_START(PC0)) u_core (.clk_in, .rstn_in, .slow_in(slow), .op_in(op), .core_rsp_in(crsp),
    .core_req_out(creq), .mem_rdata_out(mrd));

  // Clock and a hang limit well above the run length
  initial forever #25 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Each channel is released at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = ICU_RESP_OKAY);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge clk_in);
      if (!aw && s_axi_awready)
      begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready)
      begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    while (!(aw && w));
    while (!s_axi_bvalid) @(posedge clk_in);
    chk("bresp", s_axi_bresp, er);
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = ICU_RESP_OKAY);
    @(posedge clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk_in); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid) @(posedge clk_in);
    chk($sformatf("read %h", a), s_axi_rdata, e);
    chk("rresp", s_axi_rresp, er);
    s_axi_rready <= 0;
  endtask

  task automatic run_op(input logic [2:0] o);
    @(posedge clk_in);
    op <= o;
    @(posedge clk_in);
    op <= 0;
    repeat (12) @(posedge clk_in);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_in);
    rstn_in <= 1;
    for (k = 0; k < 7; k++) rd(8'(4 * k), 0);
    rd(8'h1c, 0, ICU_RESP_SLVERR);
    wr(8'h1c, 32'hf, ICU_RESP_SLVERR);
    st = 0;
    // Every edge code with random source levels, all enables off
    for (c = 0; c < 4; c++)
    begin
      wr(ICU_OFS_EDGE, 32'h55 * c);
      wr(ICU_OFS_FLAG, 0);
      fl = 0;
      for (k = 0; k < 6; k++)
      begin
        @(posedge clk_in);
        old = src;
        nw = $random(seed) & 15;
        src <= 4'(nw);
        ev = (c == 0) ? (old ^ nw) : (c == 1) ? (nw & ~old) : (c == 2) ? (old & ~nw) : 0;
        fl |= ev;
        st |= ev;
        @(posedge clk_in);
      end
      repeat (3) @(posedge clk_in);
      rd(ICU_OFS_FLAG, fl);
      wr(ICU_OFS_FLAG, 15);
      rd(ICU_OFS_FLAG, fl);
      wr(ICU_OFS_FLAG, 15 & ~(1 << c));
      fl &= ~(1 << c);
      rd(ICU_OFS_FLAG, fl);
    end
    chk("sp", sp, 0);
    rd(ICU_OFS_IRQ_STAT, st);
    chk("irq", irq, 0);
    wr(ICU_OFS_IRQ_MASK, 15);
    repeat (2) @(posedge clk_in);
    chk("irq", irq, st != 0);
    wr(ICU_OFS_IRQ_STAT, 15);
    repeat (2) @(posedge clk_in);
    chk("irq", irq, 0);
    rd(ICU_OFS_IRQ_STAT, 0);
    // Pin only enabled, two bytes of stack at an even pointer
    wr(ICU_OFS_EDGE, 0);
    wr(ICU_OFS_FLAG, 0);
    wr(ICU_OFS_ENABLE, 1);
    wr(ICU_OFS_SP, 8'h20);
    slow <= 1;
    @(posedge clk_in);
    src <= src ^ 4'h8;
    run_op(3'b001);
    chk("ge", ge, 1);
    chk("sp", sp, 8'h20);
    @(posedge clk_in);
    src <= src ^ 4'h1;
    repeat (12) @(posedge clk_in);
    chk("sp", sp, 8'h22);
    chk("ge", ge, 0);
    chk("pc", creq.pc, ICU_VECTOR);
    chk("stack", u_core.mem[16], PC0);
    wr(ICU_OFS_FLAG, 32'he);
    rd(ICU_OFS_FLAG, 8);
    run_op(3'b100);
    chk("sp", sp, 8'h20);
    chk("ge", ge, 1);
    chk("pc", creq.pc, PC0);
    run_op(3'b010);
    src <= src ^ 4'h1;
    repeat (12) @(posedge clk_in);
    chk("sp", sp, 8'h20);
    chk("ge", ge, 0);
    // Software clear of the pin flag lands on the edge that sets it again
    fork
      wr(ICU_OFS_FLAG, 32'he);
      begin
        repeat (2) @(posedge clk_in);
        src <= src ^ 4'h1;
      end
    join
    rd(ICU_OFS_FLAG, 9);
    // Comparator toggles while frozen; the edge must still count once enabled
    ce <= 0;
    @(posedge clk_in);
    src <= src ^ 4'h2;
    repeat (2) @(posedge clk_in);
    ce <= 1;
    rd(ICU_OFS_FLAG, 32'hb);
    // Global enable written by software lets the pending pin flag enter
    wr(ICU_OFS_GLOBAL, 1);
    repeat (12) @(posedge clk_in);
    chk("sp", sp, 8'h22);
    chk("ge", ge, 0);
    print_verdict();
  end
endmodule // icu_top_tb
